/* File: cpa_host.sv */
// serial host model driving the programming port of the bank
// assumes the bank synchronises its pins and commits a write within a few clk
`timescale 1ns/10ps
`default_nettype none
module cpa_host (
    input wire logic CLK,
    input wire logic SDO,
    output logic SCK,
    output logic CS_N,
    output logic SDI
);
    // idle levels: clock low, select high
    initial begin
        SCK = 1'b0;
        CS_N = 1'b1;
        SDI = 1'b0;
    end
    // wait n clk rises
    task automatic wt(input int n);
        repeat (n) @(posedge CLK);
    endtask : wt
    // one 24-bit frame msb first; read data is taken on rises 9..24
    task automatic xfer(input logic [23:0] frm, output logic [15:0] rd);
        rd = 16'h0;
        CS_N <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            wt(6);
            SDI <= frm[i];
            wt(6);
            if (i < 16) begin
                rd[i] = SDO; // shifted out on the previous fall
            end
            SCK <= 1'b1;
            wt(6);
            SCK <= 1'b0;
        end
        wt(6);
        CS_N <= 1'b1;
        SDI <= ~SDI; // released line: show no stale data
        wt(8); // covers the gap between frames and the commit lag
    endtask : xfer
endmodule : cpa_host
`default_nettype wire

/* File: cpa_pkg.sv */
// constants for the charge-pump and oscillator amplitude configuration bank
// assumes a serial programming port with 24-bit frames, msb first
package cpa_pkg;
    // serial frame layout: r/w flag, 7-bit address, 16-bit data
    localparam int FRAME_BITS = 24;
    localparam int ADDR_BITS = 7;
    localparam int DATA_BITS = 16;
    localparam int HDR_BITS = 8;
    localparam int RW_POS = 23;
    localparam logic [4:0] CNT_FRAME = 5'h18;
    localparam logic [4:0] CNT_HDR_LAST = 5'h07;
    localparam logic [4:0] CNT_MAX = 5'h1f;
    // register indices on the serial port
    localparam logic [6:0] IDX_OSC_OVR = 7'h08;
    localparam logic [6:0] IDX_CP_CUR = 7'h0e;
    localparam logic [6:0] IDX_OSC_AMP = 7'h13;
    // charge_pump_current_cfg fields
    localparam int GAIN_LSB = 0;
    localparam int GAIN_MSB = 1;
    localparam int UP_LSB = 2;
    localparam int UP_MSB = 6;
    localparam int DN_LSB = 7;
    localparam int DN_MSB = 11;
    // oscillator_amplitude_cfg field
    localparam int AMP_LSB = 3;
    localparam int AMP_MSB = 11;
    // override bit in its own register
    localparam int OVR_POS = 13;
    // reset values: up 3, down 3, coarse gain 1
    localparam logic [15:0] RST_CP_CUR = 16'h018d;
    // amplitude code 300 in bits 11:3
    localparam logic [15:0] RST_OSC_AMP = 16'h0960;
    // override clear, autocal in use
    localparam logic [15:0] RST_OSC_OVR = 16'h0000;
    // coarse gain codes and the multiplier in half steps
    localparam logic [1:0] GAIN_CODE_X1 = 2'h0;
    localparam logic [1:0] GAIN_CODE_X2 = 2'h1;
    localparam logic [1:0] GAIN_CODE_X1P5 = 2'h2;
    localparam logic [1:0] GAIN_CODE_X2P5 = 2'h3;
    localparam logic [2:0] HALVES_X1 = 3'h2;
    localparam logic [2:0] HALVES_X2 = 3'h4;
    localparam logic [2:0] HALVES_X1P5 = 3'h3;
    localparam logic [2:0] HALVES_X2P5 = 3'h5;
endpackage : cpa_pkg

/* File: cpa_reg_bank.sv */
// charge-pump current and oscillator amplitude configuration bank
// assumes serial port pins from off chip, sck well below clk/8,
// and an amplitude calibration engine on clk feeding its result in
// Contract
// - up current: bits 6:2, reset 3
// - down current: bits 11:7, reset 3; equals up (not enforced: bits 11:7 are written apart from the up field)
// - every current bit enables its own leg
// - coarse gain 1:0, reset 1: x1,x2,x1.5,x2.5
// - amplitude code: bits 11:3, reset 300
// - override set: amplitude from programmed code
// - override bit 13, reset 0, autocal on
`timescale 1ns/10ps
`default_nettype none
module cpa_reg_bank (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic SCK, // serial clock pin
    input wire logic CS_N, // serial select pin, low in a frame
    input wire logic SDI, // serial data in pin
    output logic SDO, // serial read data
    output logic SDO_OE, // high while read data is driven
    input wire logic [cpa_pkg::AMP_MSB-cpa_pkg::AMP_LSB:0] AUTOCAL_AMPLITUDE, // calibration result
    output logic [cpa_pkg::UP_MSB-cpa_pkg::UP_LSB:0] PUMP_UP_CURRENT, // per-bit leg enables
    output logic [cpa_pkg::DN_MSB-cpa_pkg::DN_LSB:0] PUMP_DOWN_CURRENT, // per-bit leg enables
    output logic [2:0] PUMP_GAIN_HALVES, // coarse multiplier in half steps
    output logic [cpa_pkg::AMP_MSB-cpa_pkg::AMP_LSB:0] OSC_AMPLITUDE_CODE, // amplitude to oscillator
    output logic AMPLITUDE_AUTOCAL_ENABLE // calibration engine allowed
);
    import cpa_pkg::*;

    localparam int AW = AMP_MSB - AMP_LSB + 1;

    // synchronised pins and edge history
    logic sck_s, cs_n_s, sdi_s; // second-stage outputs
    logic sck_d_ff, cs_n_d_ff; // previous synchronised levels
    logic [FRAME_BITS-1:0] in_sh_ff; // incoming frame shifter
    logic [4:0] bit_cnt_ff; // bits taken this frame, saturating
    logic [DATA_BITS-1:0] rd_sh_ff; // outgoing read shifter
    logic rd_act_ff; // read data phase in progress
    logic sdo_ff, sdo_oe_ff;
    // register storage
    logic [DATA_BITS-1:0] cp_cfg_ff; // charge_pump_current_cfg
    logic [DATA_BITS-1:0] amp_cfg_ff; // oscillator_amplitude_cfg
    logic [DATA_BITS-1:0] ovr_cfg_ff; // register with the amplitude override
    logic [2:0] gain_ff; // decoded coarse gain
    logic [AW-1:0] amp_out_ff; // selected amplitude
    logic autocal_en_ff;

    cpa_sync #(.WIDTH(3), .RST_VAL(3'b010)) u_sync (
        .CLK(CLK),
        .ARST_N(ARST_N),
        .D({SCK, CS_N, SDI}),
        .Q({sck_s, cs_n_s, sdi_s})
    );

    // edge and frame decode
    wire sck_rise = sck_s & ~sck_d_ff;
    wire sck_fall = ~sck_s & sck_d_ff;
    wire cs_rise = cs_n_s & ~cs_n_d_ff; // frame end
    wire in_frame = ~cs_n_s;
    wire take_bit = in_frame & sck_rise;
    wire [FRAME_BITS-1:0] nxt_in_sh = {in_sh_ff[FRAME_BITS-2:0], sdi_s};
    wire [4:0] nxt_bit_cnt = (bit_cnt_ff == CNT_MAX) ? CNT_MAX : bit_cnt_ff + 5'h01;
    wire frame_ok = cs_rise & (bit_cnt_ff == CNT_FRAME) & ~in_sh_ff[RW_POS];
    wire [ADDR_BITS-1:0] wr_addr = in_sh_ff[DATA_BITS +: ADDR_BITS];
    wire [DATA_BITS-1:0] wr_data = in_sh_ff[DATA_BITS-1:0];
    wire wr_cp = frame_ok & (wr_addr == IDX_CP_CUR);
    wire wr_amp = frame_ok & (wr_addr == IDX_OSC_AMP);
    wire wr_ovr = frame_ok & (wr_addr == IDX_OSC_OVR);
    // header complete on this edge: start a read when flagged
    wire hdr_done = take_bit & (bit_cnt_ff == CNT_HDR_LAST);
    wire rd_start = hdr_done & nxt_in_sh[HDR_BITS-1];
    wire [ADDR_BITS-1:0] rd_addr = nxt_in_sh[ADDR_BITS-1:0];
    // unmapped addresses read as zero
    wire [DATA_BITS-1:0] rd_word = (rd_addr == IDX_CP_CUR) ? cp_cfg_ff :
                                   (rd_addr == IDX_OSC_AMP) ? amp_cfg_ff :
                                   (rd_addr == IDX_OSC_OVR) ? ovr_cfg_ff : '0;
    // override and coarse gain decode
    wire ovr_on = ovr_cfg_ff[OVR_POS];
    wire [1:0] gain_code = cp_cfg_ff[GAIN_MSB:GAIN_LSB];
    wire [2:0] nxt_gain = (gain_code == GAIN_CODE_X2) ? HALVES_X2 :
                          (gain_code == GAIN_CODE_X1P5) ? HALVES_X1P5 :
                          (gain_code == GAIN_CODE_X2P5) ? HALVES_X2P5 : HALVES_X1;
    wire [AW-1:0] nxt_amp_out = ovr_on ? amp_cfg_ff[AMP_MSB:AMP_LSB] : AUTOCAL_AMPLITUDE;

    // pin edge history
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sck_d_ff <= 1'b0;
            cs_n_d_ff <= 1'b1;
        end else begin
            sck_d_ff <= sck_s;
            cs_n_d_ff <= cs_n_s;
        end
    end

    // frame shifter and bit counter; only the counter is cleared while deselected, the shifter keeps its value
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            in_sh_ff <= '0;
            bit_cnt_ff <= '0;
        end else if (take_bit) begin
            in_sh_ff <= nxt_in_sh;
            bit_cnt_ff <= nxt_bit_cnt;
        end else if (cs_n_s && !cs_rise) begin
            bit_cnt_ff <= '0;
        end
    end

    // read data: loaded after the header, shifted out on falling sck
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rd_sh_ff <= '0;
            rd_act_ff <= 1'b0;
            sdo_ff <= 1'b0;
            sdo_oe_ff <= 1'b0;
        end else if (!in_frame) begin
            rd_act_ff <= 1'b0;
            sdo_ff <= 1'b0;
            sdo_oe_ff <= 1'b0;
        end else if (rd_start) begin
            rd_sh_ff <= rd_word;
            rd_act_ff <= 1'b1;
        end else if (rd_act_ff && sck_fall) begin
            sdo_ff <= rd_sh_ff[DATA_BITS-1];
            sdo_oe_ff <= 1'b1;
            rd_sh_ff <= {rd_sh_ff[DATA_BITS-2:0], 1'b0};
        end
    end

    // charge-pump register, whole word stored for readback
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cp_cfg_ff <= RST_CP_CUR;
        end else if (wr_cp) begin
            cp_cfg_ff <= wr_data;
        end
    end

    // amplitude register
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            amp_cfg_ff <= RST_OSC_AMP;
        end else if (wr_amp) begin
            amp_cfg_ff <= wr_data;
        end
    end

    // override register
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ovr_cfg_ff <= RST_OSC_OVR;
        end else if (wr_ovr) begin
            ovr_cfg_ff <= wr_data;
        end
    end

    // decoded analog controls
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            gain_ff <= HALVES_X2; // follows reset coarse gain of 1
            amp_out_ff <= RST_OSC_AMP[AMP_MSB:AMP_LSB];
            autocal_en_ff <= 1'b1;
        end else begin
            gain_ff <= nxt_gain;
            amp_out_ff <= nxt_amp_out;
            autocal_en_ff <= ~ovr_on;
        end
    end

    // each field bit drives its own current leg, no re-encoding
    assign PUMP_UP_CURRENT = cp_cfg_ff[UP_MSB:UP_LSB];
    assign PUMP_DOWN_CURRENT = cp_cfg_ff[DN_MSB:DN_LSB];
    assign PUMP_GAIN_HALVES = gain_ff;
    assign OSC_AMPLITUDE_CODE = amp_out_ff;
    assign AMPLITUDE_AUTOCAL_ENABLE = autocal_en_ff;
    assign SDO = sdo_ff;
    assign SDO_OE = sdo_oe_ff;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    // written up field appears on the next cycle
    property p_up_write;
        wr_cp |=> PUMP_UP_CURRENT == $past(wr_data[UP_MSB:UP_LSB]);
    endproperty
    a_up_write: assert property (p_up_write) else $error("up current not loaded");

    // written down field appears on the next cycle
    property p_dn_write;
        wr_cp |=> PUMP_DOWN_CURRENT == $past(wr_data[DN_MSB:DN_LSB]);
    endproperty
    a_dn_write: assert property (p_dn_write) else $error("down current not loaded");

    // leg enables only change on a write
    property p_legs_hold;
        !wr_cp |=> $stable(PUMP_UP_CURRENT) && $stable(PUMP_DOWN_CURRENT);
    endproperty
    a_legs_hold: assert property (p_legs_hold) else $error("leg enables moved");

    // coarse gain decode
    property p_gain;
        ##1 (PUMP_GAIN_HALVES == 3'h2 && $past(gain_code) == 2'h0) || (PUMP_GAIN_HALVES == 3'h4 &&
            $past(gain_code) == 2'h1) || (PUMP_GAIN_HALVES == 3'h3 && $past(gain_code) == 2'h2) ||
            (PUMP_GAIN_HALVES == 3'h5 && $past(gain_code) == 2'h3);
    endproperty
    a_gain: assert property (p_gain) else $error("coarse gain decode wrong");

    // amplitude code write
    property p_amp_write;
        wr_amp |=> amp_cfg_ff[AMP_MSB:AMP_LSB] == $past(wr_data[AMP_MSB:AMP_LSB]);
    endproperty
    a_amp_write: assert property (p_amp_write) else $error("amplitude code not loaded");

    // override passes the programmed code
    property p_ovr_code;
        ovr_on |=> OSC_AMPLITUDE_CODE == $past(amp_cfg_ff[AMP_MSB:AMP_LSB]);
    endproperty
    a_ovr_code: assert property (p_ovr_code) else $error("override code not driven");

    // no override passes the calibration result
    property p_cal_code;
        !ovr_on |=> OSC_AMPLITUDE_CODE == $past(AUTOCAL_AMPLITUDE) && AMPLITUDE_AUTOCAL_ENABLE;
    endproperty
    a_cal_code: assert property (p_cal_code) else $error("calibration code not driven");

    // override write reaches the autocal enable two cycles on
    property p_ovr_bit;
        wr_ovr |=> ##1 AMPLITUDE_AUTOCAL_ENABLE == !$past(wr_data[OVR_POS], 2);
    endproperty
    a_ovr_bit: assert property (p_ovr_bit) else $error("override bit not applied");
endmodule : cpa_reg_bank
`default_nettype wire

/* File: cpa_sync.sv */
// two-flop synchroniser for a group of independent pin levels
// assumes each bit is a slow level unrelated to the others
`timescale 1ns/10ps
`default_nettype none
module cpa_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [WIDTH-1:0] D,
    output logic [WIDTH-1:0] Q
);
    logic [WIDTH-1:0] meta_ff; // first stage, read only by q_ff
    logic [WIDTH-1:0] q_ff; // second stage

    // two stages, reset to the idle level
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            meta_ff <= RST_VAL;
            q_ff <= RST_VAL;
        end else begin
            meta_ff <= D;
            q_ff <= meta_ff;
        end
    end

    assign Q = q_ff;
endmodule : cpa_sync
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the charge-pump and amplitude configuration bank
// assumes cpa_pkg and cpa_host are compiled first
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import cpa_pkg::*;
    logic clk, arst_n, sck, cs_n, sdi, sdo, sdo_oe, ac_en;
    logic [8:0] autocal, osc, a;
    logic [4:0] up, dn, c;
    logic [2:0] halves;
    logic [15:0] w, rd;
    int err_count, tests_run;
    int oe_cnt = 0; // clock edges with read data driven
    cpa_reg_bank u_cpa_reg_bank (.CLK(clk), .ARST_N(arst_n), .SCK(sck), .CS_N(cs_n), .SDI(sdi),
        .SDO(sdo), .SDO_OE(sdo_oe), .AUTOCAL_AMPLITUDE(autocal), .PUMP_UP_CURRENT(up),
        .PUMP_DOWN_CURRENT(dn), .PUMP_GAIN_HALVES(halves), .OSC_AMPLITUDE_CODE(osc),
        .AMPLITUDE_AUTOCAL_ENABLE(ac_en));
    cpa_host u_cpa_host (.CLK(clk), .SDO(sdo), .SCK(sck), .CS_N(cs_n), .SDI(sdi));
    // count edges at which the bank drives read data
    always @(posedge clk) begin
        if (sdo_oe === 1'b1) begin
            oe_cnt <= oe_cnt + 1;
        end
    end
    // clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // coarse gain code to multiplier in half steps
    function automatic logic [2:0] exp_halves(input logic [1:0] g);
        return (g == 2'h0) ? 3'h2 : (g == 2'h1) ? 3'h4 : (g == 2'h2) ? 3'h3 : 3'h5;
    endfunction : exp_halves
    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // register write and read frames
    task automatic wr(input logic [6:0] adr, input logic [15:0] d);
        logic [15:0] dummy;
        u_cpa_host.xfer({1'b0, adr, d}, dummy);
    endtask : wr
    task automatic rdr(input logic [6:0] adr, output logic [15:0] d);
        u_cpa_host.xfer({1'b1, adr, 16'h0}, d);
    endtask : rdr
    // verdict
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    // main sequence
    initial begin
        err_count = 0;
        tests_run = 0;
        void'($urandom(32'hc923b4b8));
        arst_n = 1'b0;
        autocal = 9'($urandom);
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        // reset state at the outputs and in the registers
        chk(16'(up), 16'h3);
        chk(16'(dn), 16'h3);
        chk(16'(halves), 16'h4);
        chk(16'(ac_en), 16'h1);
        chk(16'(osc), 16'(autocal));
        rdr(IDX_CP_CUR, rd);
        chk(rd, RST_CP_CUR);
        rdr(IDX_OSC_AMP, rd);
        chk(rd, RST_OSC_AMP);
        rdr(IDX_OSC_OVR, rd);
        chk(rd, RST_OSC_OVR);
        rdr(7'h05, rd);
        chk(rd, 16'h0);
        chk(16'(oe_cnt != 0), 16'h1);
        chk(16'(sdo_oe), 16'h0);
        $display("test reset values done");
        // every gain code; currents 0 and 31 at gains 0 and 3 go beyond the recommended set on purpose
        for (int g = 0; g < 4; g++) begin
            c = (g == 3) ? 5'h1f : (g == 0) ? 5'h00 : 5'($urandom);
            w = {4'h0, c, c, 2'(g)}; // down equals up, unnamed bits default
            wr(IDX_CP_CUR, w);
            chk(16'(up), 16'(c));
            chk(16'(dn), 16'(c));
            chk(16'(halves), 16'(exp_halves(2'(g))));
            rdr(IDX_CP_CUR, rd);
            chk(rd, w);
        end
        $display("test pump current and gain done");
        // amplitude under override, range ends and a random code
        wr(IDX_OSC_AMP, 16'h0c80);
        chk(16'(osc), 16'(autocal));
        wr(IDX_OSC_OVR, 16'h2000);
        for (int k = 0; k < 3; k++) begin
            a = (k == 0) ? 9'd250 : (k == 1) ? 9'd450 : 9'd250 + 9'($urandom_range(200));
            wr(IDX_OSC_AMP, {4'h0, a, 3'h0});
            autocal <= ~a;
            repeat (3) @(posedge clk);
            chk(16'(ac_en), 16'h0);
            chk(16'(osc), 16'(a));
            rdr(IDX_OSC_AMP, rd);
            chk(rd, {4'h0, a, 3'h0});
        end
        wr(IDX_OSC_OVR, 16'h0000);
        chk(16'(ac_en), 16'h1);
        chk(16'(osc), 16'(autocal));
        $display("test amplitude override done");
        // second reset restores the pump defaults
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk(16'(up), 16'h3);
        chk(16'(halves), 16'h4);
        chk(16'(dn), 16'h3);
        chk(16'(osc), 16'(RST_OSC_AMP[AMP_MSB:AMP_LSB]));
        chk(16'(ac_en), 16'h1);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk(16'(osc), 16'(autocal));
        rdr(IDX_OSC_OVR, rd);
        chk(rd, RST_OSC_OVR);
        rdr(IDX_CP_CUR, rd);
        chk(rd, RST_CP_CUR);
        $display("test mid-run reset done");
        end_sim();
    end
endmodule : testbench
`default_nettype wire
